// [logic/fdfl_pkg.sv]
// Constants, field layouts and carriers for the format/lock command block.
// Assumes one clock domain; shared by the core and the bench side.
package fdfl_pkg;
	// Opcode decode
	localparam logic [5:0] OP_FORMAT = 6'h0d;
	localparam logic [6:0] OP_LOCK = 7'h14;
	localparam logic [4:0] OP_READ = 5'h06;
	localparam logic [4:0] OP_READ_DEL = 5'h0c;
	localparam logic [4:0] OP_WRITE = 5'h05;
	localparam logic [4:0] OP_WRITE_DEL = 5'h09;
	localparam logic [4:0] OP_SCAN_EQ = 5'h11;
	localparam logic [4:0] OP_SCAN_LE = 5'h19;
	localparam logic [4:0] OP_SCAN_HE = 5'h1d;
	localparam logic [4:0] OP_VERIFY = 5'h16;
	// Command byte counts and positions
	localparam logic [3:0] FMT_CMD_LEN = 4'h6;
	localparam logic [3:0] XFER_CMD_LEN = 4'h9;
	localparam int CB_DRIVE = 1;
	localparam int CB_SIZE = 2;
	localparam int CB_SECTORS = 3;
	localparam int CB_GAP3 = 4;
	localparam int CB_FILL = 5;
	localparam int XB_GAP2 = 7;
	// Result phase
	localparam logic [2:0] FMT_RES_LEN = 3'h7;
	localparam logic [7:0] ST0_INVALID = 8'h80;
	localparam int LOCK_RES_BIT = 4;
	localparam int MS_RQM = 7;
	localparam int MS_DIO = 6;
	localparam int MS_BUSY = 4;
	// Track stream bytes
	localparam logic [7:0] ID_MARK = 8'hfe;
	localparam logic [7:0] DATA_MARK = 8'hfb;
	localparam logic [7:0] GAP_FM = 8'hff;
	localparam logic [7:0] GAP_MFM = 8'h4e;
	localparam logic [14:0] SECT_BASE = 15'h0080;
	// Reset values of held settings
	localparam logic RST_FIFO_DISABLE = 1'b1;
	localparam logic [3:0] RST_FIFO_THRESHOLD = 4'h0;
	localparam logic [7:0] RST_PRECOMP_START_TRACK = 8'h00;

	typedef struct packed {
		logic fifo_disable;
		logic [3:0] fifo_threshold;
		logic [7:0] precomp_start_track;
		logic fifo_write_disable;
		logic fifo_read_disable;
		logic burst_disable;
	} fdfl_cfg_s;

	localparam fdfl_cfg_s CFG_DEFAULT = '{RST_FIFO_DISABLE, RST_FIFO_THRESHOLD,
		RST_PRECOMP_START_TRACK, 1'b0, 1'b0, 1'b0};

	// Data-transfer command handed on, gap 2 byte left out
	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] drive_head;
		logic [7:0] cylinder;
		logic [7:0] head;
		logic [7:0] sector;
		logic [7:0] size_code;
		logic [7:0] last_sector_number;
		logic [7:0] data_length;
	} fdfl_xfer_s;

	typedef enum logic [3:0] {
		ST_CMD, ST_IDX1, ST_GETID, ST_AM, ST_IDW, ST_DM, ST_DATA, ST_GAP, ST_TAIL, ST_RES
	} fdfl_state_e;
endpackage

// [logic/fdfl_core.sv]
// Command, execution and result phases for track format, invalid opcodes,
// lock, and hand-off of data-transfer commands to a separate engine.
// Assumes host bytes, soft reset and settings loads come on clk; the index
// pin is asynchronous.
// Operation
// - Size codes 0..7 give 128..16384 bytes
// - Fourth byte sets sector count formatted
// - Fifth byte sets gap 3 byte count
// - Sixth byte fills every data field
// - Whole track formatted in one command
// - Format returns seven bytes, three meaningful
// - Gap 2 byte of transfers ignored
// - Illegal opcode returns only status byte zero
// - Illegal opcode: no interrupt, status bit 7 set, bit 6 clear
// - Lock byte: bit7 value, pattern 0010100
// - Lock value taken when result read
// - Reset before result read drops lock
// - Lock keeps listed settings over soft reset
// - Lock result: value in bit 4
// - Hardware reset restores all held settings
// - Formatting starts after index pulse
// - Next index ends format, interrupt, results
// - Opcode bit 6 selects FM or MFM
`timescale 1ns/10ps
module fdfl_core
	import fdfl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic soft_rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	output logic cmd_ready,
	output logic res_valid,
	output logic [7:0] res_data,
	input wire logic res_ready,
	input wire logic id_valid,
	input wire logic [7:0] id_data,
	output logic id_ready,
	input wire logic index_pin,
	output logic wr_valid,
	output logic [7:0] wr_data,
	output logic wr_mark,
	output logic wr_mfm,
	input wire logic wr_ready,
	output logic [7:0] main_status,
	output logic irq,
	output logic xfer_start,
	output fdfl_xfer_s xfer_cmd,
	input wire logic cfg_load,
	input wire fdfl_cfg_s cfg_in,
	output fdfl_cfg_s cfg,
	output logic lock
);
	// Size code to data field length; codes above 7 clamp to the largest
	function automatic logic [14:0] sector_len(input logic [7:0] code);
		return SECT_BASE << ((code > 8'h07) ? 3'h7 : code[2:0]);
	endfunction
	function automatic logic is_xfer(input logic [7:0] op);
		return op[4:0] inside {OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_SCAN_EQ,
			OP_SCAN_LE, OP_SCAN_HE, OP_VERIFY};
	endfunction
	fdfl_state_e state, next_state;
	logic [7:0] cmd_buf [0:8], next_cmd_buf [0:8];
	logic [7:0] res_buf [0:6], next_res_buf [0:6];
	logic [7:0] id_buf [0:3], next_id_buf [0:3];
	logic [3:0] bidx, next_bidx, need, next_need;
	logic [2:0] ridx, next_ridx, rlen, next_rlen;
	logic [14:0] cnt, next_cnt;
	logic [7:0] secs, next_secs;
	logic lock_pend, next_lock_pend, lock_val, next_lock_val;
	logic next_lock, next_irq, next_xfer_start;
	fdfl_cfg_s next_cfg;
	fdfl_xfer_s next_xfer_cmd;
	logic idx_s1, idx_s2, idx_s3, index_rise;

	// Index pin is asynchronous: two flops, then a third for the edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{idx_s1, idx_s2, idx_s3} <= 3'b000;
		end else begin
			{idx_s3, idx_s2, idx_s1} <= {idx_s2, idx_s1, index_pin};
		end
	end
	assign index_rise = idx_s2 & ~idx_s3;
	// Handshakes and stream byte from current state
	always_comb begin
		cmd_ready = (state == ST_CMD);
		res_valid = (state == ST_RES);
		res_data = res_buf[ridx];
		id_ready = (state == ST_GETID);
		wr_valid = 1'b0;
		wr_data = cmd_buf[0][6] ? GAP_MFM : GAP_FM;
		wr_mark = 1'b0;
		wr_mfm = cmd_buf[0][6];
		unique case (state)
			ST_AM: begin
				wr_valid = 1'b1;
				wr_data = ID_MARK;
				wr_mark = 1'b1;
			end
			ST_IDW: begin
				wr_valid = 1'b1;
				wr_data = id_buf[cnt[1:0]];
			end
			ST_DM: begin
				wr_valid = 1'b1;
				wr_data = DATA_MARK;
				wr_mark = 1'b1;
			end
			ST_DATA: begin
				wr_valid = 1'b1;
				wr_data = cmd_buf[CB_FILL];
			end
			ST_GAP, ST_TAIL: wr_valid = 1'b1;
			default: ;
		endcase
		// Request-for-master and direction; bits 7,6 both set in results
		main_status = 8'h00;
		main_status[MS_RQM] = (state == ST_CMD) || (state == ST_RES);
		main_status[MS_DIO] = (state == ST_RES);
		main_status[MS_BUSY] = (state != ST_CMD);
	end
	// Next-state logic for the whole command engine
	always_comb begin
		next_state = state;
		next_cmd_buf = cmd_buf;
		next_res_buf = res_buf;
		next_id_buf = id_buf;
		next_bidx = bidx;
		next_need = need;
		next_ridx = ridx;
		next_rlen = rlen;
		next_cnt = cnt;
		next_secs = secs;
		next_lock_pend = lock_pend;
		next_lock_val = lock_val;
		next_lock = lock;
		next_irq = 1'b0;
		next_xfer_start = 1'b0;
		next_xfer_cmd = xfer_cmd;
		next_cfg = cfg_load ? cfg_in : cfg;
		unique case (state)
			ST_CMD: if (cmd_valid) begin
				next_cmd_buf[bidx] = cmd_data;
				next_bidx = bidx + 4'h1;
				if (bidx == 4'h0) begin
					next_rlen = 3'h1;
					if (cmd_data[6:0] == OP_LOCK) begin
						next_res_buf[0] = 8'h00;
						next_res_buf[0][LOCK_RES_BIT] = cmd_data[7];
						next_lock_pend = 1'b1;
						next_lock_val = cmd_data[7];
						next_bidx = 4'h0;
						next_state = ST_RES;
					end else if (!cmd_data[7] && cmd_data[5:0] == OP_FORMAT) begin
						next_need = FMT_CMD_LEN;
					end else if (is_xfer(cmd_data)) begin
						next_need = XFER_CMD_LEN;
					end else begin
						// Straight to results, no interrupt raised
						next_res_buf[0] = ST0_INVALID;
						next_bidx = 4'h0;
						next_state = ST_RES;
					end
				end else if (bidx + 4'h1 == need) begin
					next_bidx = 4'h0;
					if (need == FMT_CMD_LEN) begin
						next_state = ST_IDX1;
					end else begin
						// Gap 2 byte is captured but never passed on
						next_xfer_cmd = '{cmd_buf[0], cmd_buf[1], cmd_buf[2], cmd_buf[3],
							cmd_buf[4], cmd_buf[5], cmd_buf[6], cmd_data};
						next_xfer_start = 1'b1;
					end
				end
			end
			ST_IDX1: if (index_rise) begin
				next_secs = 8'h00;
				next_cnt = 15'h0000;
				next_state = (cmd_buf[CB_SECTORS] == 8'h00) ? ST_TAIL : ST_GETID;
			end
			ST_GETID: if (id_valid) begin
				next_id_buf[cnt[1:0]] = id_data;
				next_cnt = cnt + 15'h0001;
				if (cnt[1:0] == 2'h3) begin
					next_cnt = 15'h0000;
					next_state = ST_AM;
				end
			end
			ST_AM: if (wr_ready) next_state = ST_IDW;
			ST_IDW: if (wr_ready) begin
				next_cnt = cnt + 15'h0001;
				if (cnt[1:0] == 2'h3) begin
					next_cnt = 15'h0000;
					next_state = ST_DM;
				end
			end
			ST_DM: if (wr_ready) begin
				next_cnt = sector_len(cmd_buf[CB_SIZE]);
				next_state = ST_DATA;
			end
			ST_DATA: if (wr_ready) begin
				next_cnt = cnt - 15'h0001;
				if (cnt == 15'h0001) begin
					next_cnt = {7'h00, cmd_buf[CB_GAP3]};
					next_state = (cmd_buf[CB_GAP3] == 8'h00) ? ST_GETID : ST_GAP;
					next_secs = secs + 8'h01;
					if (secs + 8'h01 == cmd_buf[CB_SECTORS]) next_state = ST_TAIL;
				end
			end
			ST_GAP: if (wr_ready) begin
				next_cnt = cnt - 15'h0001;
				if (cnt == 15'h0001) begin
					next_cnt = 15'h0000;
					next_state = ST_GETID;
				end
			end
			ST_TAIL: ; // Gap filler runs to the end of the track
			ST_RES: if (res_ready) begin
				next_ridx = ridx + 3'h1;
				if (ridx + 3'h1 == rlen) begin
					next_ridx = 3'h0;
					next_state = ST_CMD;
					if (lock_pend) begin
						next_lock = lock_val;
						next_lock_pend = 1'b0;
					end
				end
			end
			default: next_state = ST_CMD;
		endcase
		// Second index closes the track whatever sector is in progress
		if (index_rise && state inside {ST_GETID, ST_AM, ST_IDW, ST_DM, ST_DATA, ST_GAP,
			ST_TAIL}) begin
			next_res_buf[0] = {5'h00, cmd_buf[CB_DRIVE][2:0]};
			for (int i = 1; i < 7; i++) next_res_buf[i] = 8'h00;
			next_rlen = FMT_RES_LEN;
			next_ridx = 3'h0;
			next_irq = 1'b1;
			next_state = ST_RES;
		end
		// Soft reset: pending lock dropped, lock decides what survives
		if (soft_rst) begin
			next_state = ST_CMD;
			next_bidx = 4'h0;
			next_ridx = 3'h0;
			next_lock_pend = 1'b0;
			next_irq = 1'b0;
			next_xfer_start = 1'b0;
			if (!lock) next_cfg = CFG_DEFAULT;
		end
	end
	// Registers; hardware reset returns every held setting to default
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_CMD;
			for (int i = 0; i < 9; i++) cmd_buf[i] <= 8'h00;
			for (int i = 0; i < 7; i++) res_buf[i] <= 8'h00;
			for (int i = 0; i < 4; i++) id_buf[i] <= 8'h00;
			bidx <= 4'h0;
			need <= 4'h0;
			ridx <= 3'h0;
			rlen <= 3'h1;
			cnt <= 15'h0000;
			secs <= 8'h00;
			lock_pend <= 1'b0;
			lock_val <= 1'b0;
			lock <= 1'b0;
			irq <= 1'b0;
			xfer_start <= 1'b0;
			xfer_cmd <= '0;
			cfg <= CFG_DEFAULT;
		end else begin
			state <= next_state;
			cmd_buf <= next_cmd_buf;
			res_buf <= next_res_buf;
			id_buf <= next_id_buf;
			bidx <= next_bidx;
			need <= next_need;
			ridx <= next_ridx;
			rlen <= next_rlen;
			cnt <= next_cnt;
			secs <= next_secs;
			lock_pend <= next_lock_pend;
			lock_val <= next_lock_val;
			lock <= next_lock;
			irq <= next_irq;
			xfer_start <= next_xfer_start;
			xfer_cmd <= next_xfer_cmd;
			cfg <= next_cfg;
		end
	end

endmodule

// [sim/fdfl_core_chk.sv]
// Checker for the format/lock command block, watching top-level ports.
// Assumes a bind onto fdfl_core; one clock, synchronous active-high reset.
`timescale 1ns/10ps
module fdfl_core_chk
	import fdfl_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic soft_rst,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_ready,
	input wire logic res_valid,
	input wire logic [7:0] res_data,
	input wire logic res_ready,
	input wire logic [7:0] main_status,
	input wire logic irq,
	input wire logic cfg_load,
	input wire fdfl_cfg_s cfg,
	input wire logic lock
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Bytes taken in the current command, so opcode checks skip parameter bytes
	logic [3:0] nb, len, first_len;
	always_comb begin
		first_len = 4'h1;
		if (!cmd_data[7] && cmd_data[5:0] == OP_FORMAT) first_len = FMT_CMD_LEN;
		else if (cmd_data[4:0] inside {OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL,
			OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE, OP_VERIFY}) first_len = XFER_CMD_LEN;
	end
	always_ff @(posedge clk) begin
		if (sys_rst || soft_rst || !cmd_ready) begin
			nb <= 4'h0;
			len <= 4'h1;
		end else if (cmd_valid) begin
			if (nb == 4'h0) len <= first_len;
			nb <= ((nb == 4'h0 ? first_len : len) == nb + 4'h1) ? 4'h0 : nb + 4'h1;
		end
	end
	// Host-visible phase flags
	idle_status_a: assert property (cmd_ready |-> main_status == 8'h80)
		else $error("main status wrong in command phase");
	res_status_a: assert property (res_valid |-> main_status == 8'hd0)
		else $error("main status wrong in result phase");
	// Illegal opcode goes straight to one status byte, quietly
	invalid_res_a: assert property (cmd_valid && cmd_ready && nb == 4'h0
		&& cmd_data == 8'h00 |=> res_valid && res_data == ST0_INVALID)
		else $error("no status byte for bad opcode");
	invalid_quiet_a: assert property (cmd_valid && cmd_ready && nb == 4'h0
		&& cmd_data == 8'h00 |=> !irq [*4]) else $error("interrupt after bad opcode");
	// Lock result echoes the request; commit waits for the read
	lock_res_a: assert property (cmd_valid && cmd_ready && nb == 4'h0
		&& cmd_data[6:0] == OP_LOCK
		|=> res_valid && res_data == {3'h0, $past(cmd_data[7]), 4'h0})
		else $error("lock result byte wrong");
	lock_commit_a: assert property (!$stable(lock) |-> $past(res_valid && res_ready))
		else $error("lock moved without result read");
	// Soft reset keeps settings only while locked; format-end interrupt leads to results
	soft_keep_a: assert property (soft_rst && lock && !cfg_load |=> $stable(cfg))
		else $error("locked settings lost");
	soft_default_a: assert property (soft_rst && !lock |=> cfg == CFG_DEFAULT)
		else $error("settings not defaulted");
	end_result_a: assert property (irq |-> ##[0:2] res_valid)
		else $error("no result phase after format end");
endmodule

// [sim/fdfl_dma.sv]
// Host-side ID byte source for the format execution phase.
// Assumes id_ready from the core; LAG+1 idle cycles between bytes.
`timescale 1ns/10ps
module fdfl_dma #(parameter int LAG = 2) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic id_ready,
	output logic id_valid,
	output logic [7:0] id_data
);
	logic [7:0] seq;
	logic [3:0] wt;
	// Counting bytes; idle line shows the inverse so stale data is caught
	always @(posedge clk) begin
		if (sys_rst) begin
			id_valid <= 1'b0;
			seq <= 8'h00;
			wt <= 4'h0;
			id_data <= 8'hff;
		end else if (id_valid && id_ready) begin
			id_valid <= 1'b0;
			id_data <= ~seq;
			seq <= seq + 8'h01;
			wt <= 4'(LAG);
		end else if (wt != 4'h0) begin
			wt <= wt - 4'h1;
		end else if (id_ready) begin
			id_valid <= 1'b1;
			id_data <= seq;
		end
	end
endmodule

// [sim/fdfl_core_tb.sv]
// Self-checking bench for the format/lock command block.
// Assumes the ID byte model beside it and the checker bound below.
`timescale 1ns/10ps
module fdfl_core_tb import fdfl_pkg::*;;
	localparam fdfl_cfg_s CFG_X = '{1'b0, 4'ha, 8'h3c, 1'b1, 1'b1, 1'b1};
	logic clk = 0, sys_rst = 1, soft_rst = 0, cmd_valid = 0, res_ready = 0;
	logic index_pin = 0, wr_ready = 1, cfg_load = 0, stall = 0;
	logic [7:0] cmd_data = 8'h00;
	fdfl_cfg_s cfg_in = CFG_DEFAULT;
	logic cmd_ready, res_valid, id_valid, id_ready, wr_valid, wr_mark, wr_mfm, irq, xfer_start, lock;
	logic [7:0] res_data, id_data, wr_data, main_status;
	fdfl_xfer_s xfer_cmd;
	fdfl_cfg_s cfg;
	int error_cnt = 0, cmp_count = 0, irq_cnt = 0, nid = 0;
	logic [7:0] bad [3] = '{8'h00, 8'hff, 8'h8d};
	logic [4:0] xop [8] = '{OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL, OP_SCAN_EQ,
		OP_SCAN_LE, OP_SCAN_HE, OP_VERIFY};
	logic [63:0] x;
	logic [7:0] b;
	fdfl_core u_fdfl_core (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
		.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
		.id_valid(id_valid), .id_data(id_data), .id_ready(id_ready), .index_pin(index_pin),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_mark(wr_mark), .wr_mfm(wr_mfm),
		.wr_ready(wr_ready), .main_status(main_status), .irq(irq), .xfer_start(xfer_start),
		.xfer_cmd(xfer_cmd), .cfg_load(cfg_load), .cfg_in(cfg_in), .cfg(cfg), .lock(lock));
	fdfl_dma #(.LAG(2)) u_fdfl_dma (.clk(clk), .sys_rst(sys_rst), .id_ready(id_ready),
		.id_valid(id_valid), .id_data(id_data));
	// Clock, drive-side stalls and interrupt counting
	always #2.5 clk = ~clk;
	always @(posedge clk) wr_ready <= stall ? ~wr_ready : 1'b1;
	always @(negedge clk) if (irq === 1'b1) irq_cnt++;
	task chk(input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	// Command byte held until the core takes it
	task wc(input logic [7:0] v);
		int t;
		t = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_data <= v;
		@(negedge clk);
		while (cmd_ready !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		if (t >= 100) error_cnt++;
		@(posedge clk);
		cmd_valid <= 1'b0;
	endtask
	task rd(input logic [7:0] e, input bit c);
		int t;
		t = 0;
		@(negedge clk);
		while (res_valid !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		if (t >= 100) error_cnt++;
		if (c) chk(res_data, e);
		@(posedge clk);
		res_ready <= 1'b1;
		@(posedge clk);
		res_ready <= 1'b0;
	endtask
	task pls(input int k);
		@(posedge clk);
		if (k == 0) soft_rst <= 1'b1; else if (k == 1) index_pin <= 1'b1; else cfg_load <= 1'b1;
		repeat (k + 1) @(posedge clk);
		{soft_rst, index_pin, cfg_load} <= 3'b000;
		@(negedge clk);
	endtask
	// One format run, checking every sector byte and the first four tail bytes in order
	task fmt(input logic mfm, input logic [2:0] code, input int ns, input int gp, input int fl);
		int n, t, p, len, k;
		logic [7:0] e;
		len = 6 + (128 << code) + gp;
		n = 0;
		t = 0;
		k = irq_cnt;
		for (int i = 0; i < 6; i++) wc(8'({mfm, 6'(OP_FORMAT)} * (i == 0) + 5 * (i == 1)
			+ code * (i == 2) + ns * (i == 3) + gp * (i == 4) + fl * (i == 5)));
		repeat (4) @(negedge clk);
		chk(wr_valid, 1'b0);
		pls(1);
		while (n < ns * len + 4 && t < 40000) begin
			@(negedge clk);
			t++;
			if (wr_valid && wr_ready) begin
				p = n % len;
				if (n >= ns * len || p >= len - gp) e = mfm ? GAP_MFM : GAP_FM;
				else if (p == 0) e = ID_MARK;
				else if (p == 5) e = DATA_MARK;
				else if (p < 5) e = 8'(nid + n / len * 4 + p - 1);
				else e = 8'(fl);
				chk(wr_data, e);
				chk({wr_mark, wr_mfm}, {n < ns * len && (p == 0 || p == 5), mfm});
				n++;
			end
		end
		chk(n, ns * len + 4);
		nid += 4 * ns;
		pls(1);
		repeat (8) @(negedge clk);
		chk(irq_cnt - k, 1);
		rd(8'h05, 1'b1);
		rd(8'h00, 1'b1);
		rd(8'h00, 1'b1);
		repeat (4) rd(8'h00, 1'b0);
	endtask
	task print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end
	// Main sequence: reset, bad opcodes, lock, transfers, formats
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk({main_status, lock, cfg}, {8'h80, 1'b0, CFG_DEFAULT});
		$display("reset test done");
		foreach (bad[i]) begin
			wc(bad[i]);
			rd(ST0_INVALID, 1'b1);
			@(negedge clk);
			chk({main_status, cmd_ready}, {8'h80, 1'b1});
		end
		chk(irq_cnt, 0);
		$display("bad opcode test done");
		cfg_in <= CFG_X;
		pls(2);
		wc(8'h94);
		rd(8'h10, 1'b1);
		pls(0);
		chk({lock, cfg}, {1'b1, CFG_X});
		wc(8'h14);
		pls(0);
		chk({lock, res_valid, cmd_ready}, 3'b101);
		wc(8'h14);
		rd(8'h00, 1'b1);
		pls(0);
		chk({lock, cfg}, {1'b0, CFG_DEFAULT});
		pls(2);
		sys_rst <= 1'b1;
		pls(0);
		sys_rst <= 1'b0;
		@(negedge clk);
		chk(cfg, CFG_DEFAULT);
		$display("lock test done");
		foreach (xop[i]) begin
			for (int j = 0; j < 9; j++) begin
				b = j == 0 ? {3'b010, xop[i]} : 8'(j * 16 + i);
				if (j != 7) x = {x[55:0], b};
				wc(b);
			end
			@(negedge clk);
			chk(xfer_start, 1'b1);
			chk(xfer_cmd, x);
		end
		$display("transfer test done");
		for (int i = 0; i < 9; i++) begin
			stall <= i == 1;
			fmt(i[1], 3'(i), i == 8 ? 0 : 1 + i % 2, i + 2, 8'h30 + i);
		end
		$display("format test done");
		print_verdict();
	end
endmodule
bind fdfl_core fdfl_core_chk u_fdfl_core_chk (.clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
	.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
	.res_valid(res_valid), .res_data(res_data), .res_ready(res_ready),
	.main_status(main_status), .irq(irq), .cfg_load(cfg_load), .cfg(cfg), .lock(lock));
